// file: logic/bts_pkg.sv
package bts_pkg;
	// ==========================================
	// trigger source selection
	typedef enum logic [1:0]
	{
		BTS_SRC_LEVEL = 2'b00,
		BTS_SRC_SOFT = 2'b01,
		BTS_SRC_EXT = 2'b10,
		BTS_SRC_NONE = 2'b11
	} bts_src_type;

	// ==========================================
	// input delay figures
	localparam int BTS_DELAY_STEP_PS = 78;
	localparam int BTS_DELAY_MAX_PS = 2400;
	localparam int BTS_DELAY_STEPS = BTS_DELAY_MAX_PS / BTS_DELAY_STEP_PS;
	localparam int BTS_DELAY_W = 5;
	localparam logic [BTS_DELAY_W-1:0] BTS_DELAY_TOP = BTS_DELAY_STEPS[BTS_DELAY_W-1:0];
	localparam logic [BTS_DELAY_W-1:0] BTS_DELAY_RESET = 5'h00;

	// ==========================================
	// clock figures
	localparam int BTS_CLK_MHZ = 100;
	localparam int BTS_LAT_W = 8;
	localparam logic [BTS_LAT_W-1:0] BTS_LAT_DEFAULT = 8'h10;
	localparam logic [BTS_LAT_W-1:0] BTS_LAT_ONE = 8'h01;
	localparam logic [BTS_LAT_W-1:0] BTS_LAT_ZERO = 8'h00;

	// ==========================================
	// captured trigger carrier
	typedef struct packed
	{
		logic hit;
		logic late_half;
	} bts_cap_type;

	// ==========================================
	// capture states
	typedef enum logic [1:0]
	{
		BTS_ST_IDLE = 2'b00,
		BTS_ST_WAIT = 2'b01,
		BTS_ST_PLAY = 2'b10
	} bts_state_type;
endpackage

// file: logic/bts_sync2.sv
`timescale 1ns/1ps
module bts_sync2
#(
	parameter int WIDTH = 1
)
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	// ==========================================
	// two stage synchroniser
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] meta_next;
	logic [WIDTH-1:0] sync_reg;
	logic [WIDTH-1:0] sync_next;

	always_comb
	begin
		meta_next = async_in;
		sync_next = meta_reg;
		if (!reset_n)
		begin
			meta_next = '0;
			sync_next = '0;
		end
	end

	always_ff @(posedge core_clk)
	begin
		meta_reg <= meta_next;
		sync_reg <= sync_next;
	end

	assign sync_out = sync_reg;
endmodule

// file: logic/bts_trigger.sv
`timescale 1ns/1ps
module bts_trigger
#(
	parameter logic [bts_pkg::BTS_LAT_W-1:0] LATENCY = bts_pkg::BTS_LAT_DEFAULT
)
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic is_master,
	input wire bts_pkg::bts_src_type src_sel,
	input wire logic level_hit,
	input wire logic soft_cmd,
	input wire logic ext_trig,
	input wire logic [1:0] trig_in_pair,
	input wire logic [bts_pkg::BTS_DELAY_W-1:0] nv_delay,
	input wire logic nv_valid,
	output logic trig_out,
	output logic [bts_pkg::BTS_DELAY_W-1:0] delay_tap,
	output logic play_start,
	output logic playing,
	output logic late_half
);
	// ==========================================
	// synchronise pin inputs
	logic [3:0] pins_sync;
	logic [1:0] pair_s;

	bts_sync2 #(.WIDTH(4)) u_sync
	(
		.core_clk(core_clk),
		.reset_n(reset_n),
		.async_in({ext_trig, nv_valid, trig_in_pair}),
		.sync_out(pins_sync)
	);
	assign pair_s = pins_sync[1:0];

	// ==========================================
	// trigger source and launch
	logic src_hit;
	logic src_prev_reg;
	logic src_prev_next;
	logic trig_out_reg;
	logic trig_out_next;

	always_comb
	begin
		unique case (src_sel)
			bts_pkg::BTS_SRC_LEVEL: src_hit = level_hit;
			bts_pkg::BTS_SRC_SOFT: src_hit = soft_cmd;
			bts_pkg::BTS_SRC_EXT: src_hit = pins_sync[3];
			bts_pkg::BTS_SRC_NONE: src_hit = 1'b0;
		endcase
		src_prev_next = src_hit;
		trig_out_next = is_master && src_hit && !src_prev_reg;
		if (!reset_n)
		begin
			src_prev_next = 1'b0;
			trig_out_next = 1'b0;
		end
	end

	always_ff @(posedge core_clk)
	begin
		src_prev_reg <= src_prev_next;
		trig_out_reg <= trig_out_next;
	end

	// ==========================================
	// input delay load at power-up
	logic [bts_pkg::BTS_DELAY_W-1:0] delay_reg;
	logic [bts_pkg::BTS_DELAY_W-1:0] delay_next;
	logic loaded_reg;
	logic loaded_next;

	always_comb
	begin
		delay_next = delay_reg;
		loaded_next = loaded_reg;
		if (!loaded_reg && pins_sync[2])
		begin
			delay_next = (nv_delay > bts_pkg::BTS_DELAY_TOP) ?
				bts_pkg::BTS_DELAY_TOP : nv_delay;
			loaded_next = 1'b1;
		end
		if (!reset_n)
		begin
			delay_next = bts_pkg::BTS_DELAY_RESET;
			loaded_next = 1'b0;
		end
	end

	always_ff @(posedge core_clk)
	begin
		delay_reg <= delay_next;
		loaded_reg <= loaded_next;
	end

	// ==========================================
	// capture and fixed latency start
	bts_pkg::bts_state_type state_reg;
	bts_pkg::bts_state_type state_next;
	bts_pkg::bts_cap_type cap;
	logic [1:0] pair_prev_reg;
	logic [1:0] pair_prev_next;
	logic [bts_pkg::BTS_LAT_W-1:0] cnt_reg;
	logic [bts_pkg::BTS_LAT_W-1:0] cnt_next;
	logic late_reg;
	logic late_next;
	logic start_reg;
	logic start_next;

	always_comb
	begin
		// both halves in one cycle; earliest rising half wins
		cap.hit = (pair_s[0] && !pair_prev_reg[1]) || (pair_s[1] && !pair_s[0]);
		cap.late_half = !(pair_s[0] && !pair_prev_reg[1]);
		pair_prev_next = pair_s;
		state_next = state_reg;
		cnt_next = cnt_reg;
		late_next = late_reg;
		start_next = 1'b0;
		unique case (state_reg)
			bts_pkg::BTS_ST_IDLE:
			begin
				if (cap.hit && loaded_reg)
				begin
					state_next = bts_pkg::BTS_ST_WAIT;
					cnt_next = LATENCY - bts_pkg::BTS_LAT_ONE;
					late_next = cap.late_half;
				end
			end
			bts_pkg::BTS_ST_WAIT:
			begin
				if (cnt_reg == bts_pkg::BTS_LAT_ZERO)
				begin
					state_next = bts_pkg::BTS_ST_PLAY;
					start_next = 1'b1;
				end
				else
				begin
					cnt_next = cnt_reg - bts_pkg::BTS_LAT_ONE;
				end
			end
			bts_pkg::BTS_ST_PLAY:
			begin
				if (cap.hit)
				begin
					state_next = bts_pkg::BTS_ST_WAIT;
					cnt_next = LATENCY - bts_pkg::BTS_LAT_ONE;
					late_next = cap.late_half;
				end
			end
			default: state_next = bts_pkg::BTS_ST_IDLE;
		endcase
		if (!reset_n)
		begin
			pair_prev_next = 2'b00;
			state_next = bts_pkg::BTS_ST_IDLE;
			cnt_next = bts_pkg::BTS_LAT_ZERO;
			late_next = 1'b0;
			start_next = 1'b0;
		end
	end

	always_ff @(posedge core_clk)
	begin
		pair_prev_reg <= pair_prev_next;
		state_reg <= state_next;
		cnt_reg <= cnt_next;
		late_reg <= late_next;
		start_reg <= start_next;
	end

	logic playing_reg;
	logic playing_next;
	always_comb
	begin
		playing_next = (state_next == bts_pkg::BTS_ST_PLAY);
		if (!reset_n)
		begin
			playing_next = 1'b0;
		end
	end
	always_ff @(posedge core_clk)
	begin
		playing_reg <= playing_next;
	end

	assign trig_out = trig_out_reg;
	assign delay_tap = delay_reg;
	assign play_start = start_reg;
	assign playing = playing_reg;
	assign late_half = late_reg;

	// ==========================================
	// checks
	localparam int START_CYCLES = LATENCY + 1;

	a_launch_edge: assert property (@(posedge core_clk) disable iff (!reset_n)
		trig_out |-> $past(is_master)) else $error("trigger out from non master");
	a_delay_range: assert property (@(posedge core_clk) disable iff (!reset_n)
		delay_tap <= bts_pkg::BTS_DELAY_TOP) else $error("delay tap out of range");
	a_delay_load: assert property (@(posedge core_clk) disable iff (!reset_n)
		(!loaded_reg && pins_sync[2]) |=> loaded_reg) else $error("delay not loaded");
	a_delay_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
		$past(loaded_reg) && loaded_reg |-> $stable(delay_tap)) else $error("delay moved");
	a_start_latency: assert property (@(posedge core_clk) disable iff (!reset_n)
		(state_reg != bts_pkg::BTS_ST_WAIT && cap.hit && loaded_reg)
		|-> ##START_CYCLES play_start) else $error("latency not fixed");
	a_start_play: assert property (@(posedge core_clk) disable iff (!reset_n)
		play_start |-> playing) else $error("start without play");
	a_early_half: assert property (@(posedge core_clk) disable iff (!reset_n)
		(state_reg != bts_pkg::BTS_ST_WAIT && loaded_reg && pair_s[0] && !pair_prev_reg[1])
		|=> !late_half) else $error("early half not flagged");
	a_late_half: assert property (@(posedge core_clk) disable iff (!reset_n)
		(state_reg != bts_pkg::BTS_ST_WAIT && loaded_reg && pair_s == 2'b10)
		|=> late_half) else $error("late half not flagged");
endmodule

// file: verification/backplane_trigger_sync_tb.sv
`timescale 1ns/1ps
module backplane_trigger_sync_tb;
	localparam int LAT = 2;
	logic core_clk, reset_n, is_master, level_hit, soft_cmd, ext_trig, nv_valid, late;
	bts_pkg::bts_src_type src_sel;
	logic [1:0] trig_in_pair;
	logic [4:0] nv_delay, delay_tap;
	logic trig_out, play_start, playing, late_half;
	int error_cnt, comparisons;
	bts_trigger #(.LATENCY(8'h02)) bts_trigger_i (.core_clk(core_clk), .reset_n(reset_n),
		.is_master(is_master), .src_sel(src_sel), .level_hit(level_hit),
		.soft_cmd(soft_cmd), .ext_trig(ext_trig), .trig_in_pair(trig_in_pair),
		.nv_delay(nv_delay), .nv_valid(nv_valid), .trig_out(trig_out),
		.delay_tap(delay_tap), .play_start(play_start), .playing(playing),
		.late_half(late_half));
	bts_chassis_model bts_chassis_model_i (.core_clk(core_clk), .trig_out(trig_out),
		.late(late), .trig_in_pair(trig_in_pair));
	// ==========
	// clock and checking
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	task automatic conclude();
		if (error_cnt == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wait_hi(input logic sel_play, output int n);
		n = 0;
		do
		begin
			@(negedge core_clk);
			n++;
			if (n > 40)
			begin
				error_cnt++;
				conclude();
			end
		end
		while ((sel_play ? play_start : trig_out) !== 1'b1);
	endtask
	// ==========
	// scenarios
	task automatic do_reset(input logic [4:0] d, input logic [4:0] exp);
		@(posedge core_clk);
		reset_n <= 1'b0;
		nv_valid <= 1'b0;
		nv_delay <= d;
		repeat (8) @(posedge core_clk);
		reset_n <= 1'b1;
		nv_valid <= 1'b1;
		repeat (6) @(posedge core_clk);
		@(negedge core_clk);
		check("delay_tap", {3'h0, exp}, {3'h0, delay_tap});
		check("playing", 8'h00, {7'h0, playing});
	endtask
	task automatic trig_run(input bts_pkg::bts_src_type s, input logic lt);
		int n;
		@(posedge core_clk);
		src_sel <= s;
		late <= lt;
		level_hit <= (s == bts_pkg::BTS_SRC_LEVEL);
		soft_cmd <= (s == bts_pkg::BTS_SRC_SOFT);
		ext_trig <= (s == bts_pkg::BTS_SRC_EXT);
		wait_hi(1'b0, n);
		wait_hi(1'b1, n);
		check("latency", 8'(LAT + 4), n[7:0]);
		@(negedge core_clk);
		check("play_start", 8'h00, {7'h0, play_start});
		check("playing", 8'h01, {7'h0, playing});
		check("late_half", {7'h0, lt}, {7'h0, late_half});
		@(posedge core_clk);
		level_hit <= 1'b0;
		soft_cmd <= 1'b0;
		ext_trig <= 1'b0;
		repeat (5) @(posedge core_clk);
	endtask
	task automatic slave_run();
		int hits;
		hits = 0;
		@(posedge core_clk);
		is_master <= 1'b0;
		src_sel <= bts_pkg::BTS_SRC_LEVEL;
		level_hit <= 1'b1;
		repeat (12)
		begin
			@(negedge core_clk);
			hits += trig_out;
		end
		check("slave trig_out", 8'h00, hits[7:0]);
		@(posedge core_clk);
		level_hit <= 1'b0;
	endtask
	initial
	begin
		error_cnt = 0;
		comparisons = 0;
		reset_n = 1'b0;
		is_master = 1'b1;
		src_sel = bts_pkg::BTS_SRC_NONE;
		level_hit = 1'b0;
		soft_cmd = 1'b0;
		ext_trig = 1'b0;
		nv_delay = 5'h00;
		nv_valid = 1'b0;
		late = 1'b0;
		do_reset(5'h1f, 5'h1e);
		do_reset(5'h05, 5'h05);
		trig_run(bts_pkg::BTS_SRC_LEVEL, 1'b0);
		trig_run(bts_pkg::BTS_SRC_SOFT, 1'b1);
		trig_run(bts_pkg::BTS_SRC_EXT, 1'b0);
		slave_run();
		conclude();
	end
endmodule

// file: verification/bts_chassis_model.sv
`timescale 1ns/1ps
// ==========
// chassis loopback of the launched trigger
module bts_chassis_model
(
	input wire logic core_clk,
	input wire logic trig_out,
	input wire logic late,
	output logic [1:0] trig_in_pair
);
	logic hold;
	initial
	begin
		trig_in_pair = 2'b00;
		hold = 1'b0;
	end
	always @(posedge core_clk)
	begin
		if (trig_out)
		begin
			trig_in_pair <= late ? 2'b10 : 2'b11;
			hold <= 1'b1;
		end
		else
		begin
			trig_in_pair <= hold ? 2'b11 : 2'b00;
			hold <= 1'b0;
		end
	end
endmodule
